//--- hw/iox_pkg.sv
// Shared constants and types for the I/O expander serial slave front end.
`default_nettype none
package iox_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and spike filter timing.
   localparam int CLK_PERIOD_NS = 40;
   localparam int SPIKE_NS      = 50;
   // Least time, so rounded up to whole clock cycles.
   localparam int FILT_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W        = $clog2(FILT_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Register select values carried by the command byte.
   localparam logic [2:0] REG_PIN_LEVEL_PORT_LOW  = 3'h0;
   localparam logic [2:0] REG_PIN_LEVEL_PORT_HIGH = 3'h1;
   localparam logic [2:0] REG_OUTPUT_PORT_LOW     = 3'h2;
   localparam logic [2:0] REG_OUTPUT_PORT_HIGH    = 3'h3;
   localparam logic [2:0] REG_POLARITY_PORT_LOW   = 3'h4;
   localparam logic [2:0] REG_POLARITY_PORT_HIGH  = 3'h5;
   localparam logic [2:0] REG_CONFIG_PORT_LOW     = 3'h6;
   localparam logic [2:0] REG_CONFIG_PORT_HIGH    = 3'h7;
   localparam logic [2:0] REG_PTR_RESET           = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Bus encodings and counts.
   localparam logic       RW_READ      = 1'b1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   // Address pin class: bit 1 set means tied to a bus line, bit 0 set means
   // supply or the data line.
   localparam logic [1:0] PIN_GND = 2'h0;
   localparam logic [1:0] PIN_VDD = 2'h1;
   localparam logic [1:0] PIN_SCL = 2'h2;
   localparam logic [1:0] PIN_SDA = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RX     = 3'b001,
      ST_RX_ACK = 3'b011,
      ST_TX     = 3'b010,
      ST_TX_ACK = 3'b110
   } iox_state_type;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_CMD  = 2'h1,
      PH_DATA = 2'h3
   } iox_phase_type;

   // Write strobe toward the output, polarity and configuration registers.
   typedef struct packed {
      logic       valid;
      logic [2:0] sel;
      logic [7:0] data;
   } iox_wr_type;

endpackage
`default_nettype wire

//--- hw/iox_slave_front.sv
// Serial bus slave front end with address sensing and pin level registers.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module iox_slave_front #(
   parameter int PORT_W = 8
) (
   input  wire  logic                   i_clk,
   input  wire  logic                   i_nrst,
   input  wire  logic                   i_ce,
   input  wire  logic                   i_scl,
   input  wire  logic                   i_sda,
   output logic                         o_sda_oe_n,
   input  wire  logic                   i_addr_select_pin_low,
   input  wire  logic                   i_addr_select_pin_mid,
   input  wire  logic                   i_addr_select_pin_high,
   input  wire  logic [PORT_W-1:0]      i_port_low_pin_level_bits,
   input  wire  logic [PORT_W-1:0]      i_port_high_pin_level_bits,
   output logic [PORT_W-1:0]            o_pin_level_port_low,
   output logic [PORT_W-1:0]            o_pin_level_port_high,
   output logic [2:0]                   o_rd_sel,
   input  wire  logic [PORT_W-1:0]      i_rd_data,
   output iox_pkg::iox_wr_type          o_wr
);

   if (PORT_W != 8) begin : g_bad_width
      $error("Port width must be eight bits");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pins, then spike filters on clock and data.
   logic [PORT_W-1:0] lvl_low_meta_ff;
   logic [PORT_W-1:0] lvl_low_ff;
   logic [PORT_W-1:0] lvl_high_meta_ff;
   logic [PORT_W-1:0] lvl_high_ff;
   logic [2:0]        ad_meta_ff;
   logic [2:0]        ad_ff;
   logic [1:0]        bus_meta_ff;
   logic [1:0]        bus_sync_ff;
   logic [1:0]        filt_ff;
   logic [1:0]        filt_d_ff;

   // The pin level registers hold only what the pins show; the reset value
   // is overwritten two cycles after release.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lvl_low_meta_ff  <= '0;
         lvl_low_ff       <= '0;
         lvl_high_meta_ff <= '0;
         lvl_high_ff      <= '0;
         ad_meta_ff       <= '0;
         ad_ff            <= '0;
         bus_meta_ff      <= 2'h3;
         bus_sync_ff      <= 2'h3;
         filt_d_ff        <= 2'h3;
      end else if (i_ce) begin
         lvl_low_meta_ff  <= i_port_low_pin_level_bits;
         lvl_low_ff       <= lvl_low_meta_ff;
         lvl_high_meta_ff <= i_port_high_pin_level_bits;
         lvl_high_ff      <= lvl_high_meta_ff;
         ad_meta_ff       <= {i_addr_select_pin_high, i_addr_select_pin_mid,
                              i_addr_select_pin_low};
         ad_ff            <= ad_meta_ff;
         bus_meta_ff      <= {i_sda, i_scl};
         bus_sync_ff      <= bus_meta_ff;
         filt_d_ff        <= filt_ff;
      end
   end

   assign o_pin_level_port_low  = lvl_low_ff;
   assign o_pin_level_port_high = lvl_high_ff;

   // A new level is taken only after it differs for FILT_CYC+1 samples, which
   // spans more than the longest spike to be ignored.
   for (genvar g = 0; g < 2; g++) begin : g_filt
      logic [iox_pkg::FILT_W-1:0] cnt_ff;
      logic [iox_pkg::FILT_W-1:0] nxt_cnt;
      logic                       nxt_filt;

      always_comb begin
         nxt_cnt  = '0;
         nxt_filt = filt_ff[g];
         if (bus_sync_ff[g] != filt_ff[g]) begin
            if (cnt_ff == iox_pkg::FILT_W'(iox_pkg::FILT_CYC)) begin
               nxt_filt = bus_sync_ff[g];
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
      end

      always_ff @(posedge i_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            cnt_ff     <= '0;
            filt_ff[g] <= 1'b1;
         end else if (i_ce) begin
            cnt_ff     <= nxt_cnt;
            filt_ff[g] <= nxt_filt;
         end
      end
   end

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl        = filt_ff[0];
   assign sda        = filt_ff[1];
   assign scl_rise   = scl & ~filt_d_ff[0];
   assign scl_fall   = ~scl & filt_d_ff[0];
   assign start_cond = scl & filt_d_ff[0] & ~sda & filt_d_ff[1];
   assign stop_cond  = scl & filt_d_ff[0] & sda & ~filt_d_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // Address pin sensing. Each pin is seen idle (both lines high), just after
   // START (clock high, data low) and at the first clock low; the three
   // samples tell the four ways a pin can be tied.
   logic [2:0] ad_idle_ff;
   logic [2:0] ad_start_ff;
   logic [2:0] ad_low_ff;
   logic [1:0] pin_cls [3];
   logic [6:0] dev_addr;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_cls[i][1] = ad_idle_ff[i] & ~ad_low_ff[i];
         pin_cls[i][0] = ad_idle_ff[i] & (~ad_start_ff[i] | ad_low_ff[i]);
      end
   end

   assign dev_addr = {pin_cls[2][1],
                      ~pin_cls[1][1],
                      pin_cls[1][1] | (pin_cls[2][1] & ~pin_cls[1][1] & pin_cls[0][1]),
                      pin_cls[0][1] & ~(pin_cls[2][1] & ~pin_cls[1][1]),
                      pin_cls[2][0],
                      pin_cls[1][0],
                      pin_cls[0][0]};

   ////////////////////////////////////////////////////////////////////////////
   // Byte engine.
   iox_pkg::iox_state_type state_ff;
   iox_pkg::iox_state_type nxt_state;
   iox_pkg::iox_phase_type phase_ff;
   iox_pkg::iox_phase_type nxt_phase;
   logic [3:0]          cnt_ff;
   logic [3:0]          nxt_cnt;
   logic [7:0]          shift_ff;
   logic [7:0]          nxt_shift;
   logic [2:0]          ptr_ff;
   logic [2:0]          nxt_ptr;
   logic                rw_ff;
   logic                nxt_rw;
   logic                drive_ff;
   logic                nxt_drive;
   logic                acked_ff;
   logic                nxt_acked;
   logic [2:0]          nxt_ad_idle;
   logic [2:0]          nxt_ad_start;
   logic [2:0]          nxt_ad_low;
   iox_pkg::iox_wr_type wr_ff;
   iox_pkg::iox_wr_type nxt_wr;
   logic [7:0]          rd_byte;

   // Reading during the master's acknowledge (ST_TX_ACK) uses the other register of the pair.
   assign o_rd_sel = (state_ff == iox_pkg::ST_TX_ACK) ? {ptr_ff[2:1], ~ptr_ff[0]} : ptr_ff;

   always_comb begin
      unique case (o_rd_sel)
         iox_pkg::REG_PIN_LEVEL_PORT_LOW:  rd_byte = lvl_low_ff;
         iox_pkg::REG_PIN_LEVEL_PORT_HIGH: rd_byte = lvl_high_ff;
         default:                          rd_byte = i_rd_data;
      endcase
   end

   always_comb begin
      nxt_state    = state_ff;
      nxt_phase    = phase_ff;
      nxt_cnt      = cnt_ff;
      nxt_shift    = shift_ff;
      nxt_ptr      = ptr_ff;
      nxt_rw       = rw_ff;
      nxt_drive    = drive_ff;
      nxt_acked    = acked_ff;
      // Pin samples must line up with the synchronised lines. The filtered
      // lines trail them by the filter delay, so an edge would be missed.
      nxt_ad_idle  = (scl & sda & (bus_sync_ff == 2'h3)) ? ad_ff : ad_idle_ff;
      nxt_ad_start = ad_start_ff;
      nxt_ad_low   = ad_low_ff;
      nxt_wr       = '0;
      if (stop_cond) begin
         nxt_state = iox_pkg::ST_IDLE;
         nxt_drive = 1'b0;
      end else if (start_cond) begin
         nxt_state    = iox_pkg::ST_RX;
         nxt_phase    = iox_pkg::PH_ADDR;
         nxt_cnt      = '0;
         nxt_drive    = 1'b0;
         nxt_ad_start = ad_ff;
      end else begin
         unique case (state_ff)
            iox_pkg::ST_IDLE: begin
            end
            iox_pkg::ST_RX: begin
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], sda};
                  nxt_cnt   = cnt_ff + 4'h1;
               end
               // Taken on the first synchronised clock low, before the master
               // may move the data line under a zero hold time.
               if (scl && !bus_sync_ff[0] && g_filt[0].cnt_ff == '0 &&
                   phase_ff == iox_pkg::PH_ADDR && cnt_ff == 4'h0) begin
                  nxt_ad_low = ad_ff;
               end
               if (scl_fall && cnt_ff == iox_pkg::BITS_PER_BYTE) begin
                  nxt_cnt   = '0;
                  nxt_drive = 1'b1;
                  nxt_state = iox_pkg::ST_RX_ACK;
                  unique case (phase_ff)
                     iox_pkg::PH_ADDR: begin
                        if (shift_ff[7:1] == dev_addr) begin
                           nxt_rw = shift_ff[0];
                        end else begin
                           nxt_drive = 1'b0;
                           nxt_state = iox_pkg::ST_IDLE;
                        end
                     end
                     iox_pkg::PH_CMD: begin
                        nxt_ptr = shift_ff[2:0];
                     end
                     default: begin
                        // Input port writes are acknowledged and dropped.
                        nxt_wr.valid = (ptr_ff[2:1] != 2'h0);
                        nxt_wr.sel   = ptr_ff;
                        nxt_wr.data  = shift_ff;
                        nxt_ptr      = {ptr_ff[2:1], ~ptr_ff[0]};
                     end
                  endcase
               end
            end
            iox_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  nxt_drive = 1'b0;
                  nxt_state = iox_pkg::ST_RX;
                  nxt_phase = iox_pkg::PH_DATA;
                  if (phase_ff == iox_pkg::PH_ADDR && rw_ff == iox_pkg::RW_READ) begin
                     nxt_state = iox_pkg::ST_TX;
                     nxt_shift = rd_byte;
                     nxt_drive = ~rd_byte[7];
                  end else if (phase_ff == iox_pkg::PH_ADDR) begin
                     nxt_phase = iox_pkg::PH_CMD;
                  end
               end
            end
            iox_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (cnt_ff == iox_pkg::LAST_TX_BIT) begin
                     nxt_cnt   = '0;
                     nxt_drive = 1'b0;
                     nxt_state = iox_pkg::ST_TX_ACK;
                  end else begin
                     nxt_cnt   = cnt_ff + 4'h1;
                     nxt_shift = {shift_ff[6:0], 1'b0};
                     nxt_drive = ~shift_ff[6];
                  end
               end
            end
            iox_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  nxt_acked = ~sda;
               end
               if (scl_fall) begin
                  if (acked_ff) begin
                     nxt_ptr   = o_rd_sel;
                     nxt_shift = rd_byte;
                     nxt_drive = ~rd_byte[7];
                     nxt_state = iox_pkg::ST_TX;
                  end else begin
                     nxt_state = iox_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               nxt_state = iox_pkg::ST_IDLE;
               nxt_drive = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff    <= iox_pkg::ST_IDLE;
         phase_ff    <= iox_pkg::PH_ADDR;
         cnt_ff      <= '0;
         shift_ff    <= '0;
         ptr_ff      <= iox_pkg::REG_PTR_RESET;
         rw_ff       <= 1'b0;
         drive_ff    <= 1'b0;
         acked_ff    <= 1'b0;
         ad_idle_ff  <= '0;
         ad_start_ff <= '0;
         ad_low_ff   <= '0;
         wr_ff       <= '0;
      end else if (i_ce) begin
         state_ff    <= nxt_state;
         phase_ff    <= nxt_phase;
         cnt_ff      <= nxt_cnt;
         shift_ff    <= nxt_shift;
         ptr_ff      <= nxt_ptr;
         rw_ff       <= nxt_rw;
         drive_ff    <= nxt_drive;
         acked_ff    <= nxt_acked;
         ad_idle_ff  <= nxt_ad_idle;
         ad_start_ff <= nxt_ad_start;
         ad_low_ff   <= nxt_ad_low;
         wr_ff       <= nxt_wr;
      end
   end

   // Open drain: enable low pulls the data line low, high releases it.
   assign o_sda_oe_n = ~drive_ff;
   assign o_wr       = wr_ff;

endmodule
`default_nettype wire

//--- testbench/iox_props.sv
// Checker for the port behaviour of the serial slave front end.
`default_nettype none
module iox_props #(
   parameter int PORT_W = 8
) (
   input wire logic                i_clk,
   input wire logic                i_nrst,
   input wire logic                i_ce,
   input wire logic                i_scl,
   input wire logic                o_sda_oe_n,
   input wire logic [PORT_W-1:0]   i_port_low_pin_level_bits,
   input wire logic [PORT_W-1:0]   i_port_high_pin_level_bits,
   input wire logic [PORT_W-1:0]   o_pin_level_port_low,
   input wire logic [PORT_W-1:0]   o_pin_level_port_high,
   input wire logic [2:0]          o_rd_sel,
   input wire iox_pkg::iox_wr_type o_wr
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   ////////////////////////////////////////////////////////////
   // The pin registers need two enabled edges out of reset to fill.
   pin_low_follow_a : assert property ($past(i_ce) && $past(i_ce, 2) && $past(i_nrst, 2)
      |-> o_pin_level_port_low == $past(i_port_low_pin_level_bits, 2))
      else $error("low pin level register does not follow its pins");
   pin_high_follow_a : assert property ($past(i_ce) && $past(i_ce, 2) && $past(i_nrst, 2)
      |-> o_pin_level_port_high == $past(i_port_high_pin_level_bits, 2))
      else $error("high pin level register does not follow its pins");
   wr_sel_legal_a : assert property (o_wr.valid |-> o_wr.sel > 3'h1)
      else $error("write strobe raised for a pin level register");
   wr_pulse_once_a : assert property (o_wr.valid |=> !o_wr.valid)
      else $error("write strobe longer than one cycle");
   wr_with_ack_a : assert property (o_wr.valid |-> $fell(o_sda_oe_n))
      else $error("write strobe not aligned with the acknowledge");
   wr_pair_a : assert property (o_wr.valid |-> o_wr.sel[2:1] == o_rd_sel[2:1])
      else $error("pointer left the selected register pair");
   spike_filter_a : assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 3) && !$past(i_scl, 4))
      else $error("data line changed without a settled clock low");
   ack_hold_a : assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*8])
      else $error("data line drive released too early");
endmodule
`default_nettype wire

//--- testbench/iox_master.sv
// Bus master model that drives the serial clock and the data line.
`default_nettype none
module iox_master (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int   half  = 12;
   logic spike = 1'b0;

   initial begin
      o_scl = 1'b1;
      o_sda_oe_n = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////
   // Data moves two cycles after the clock falls, so it never races it.
   task automatic start();
      tick(2);
      o_sda_oe_n <= 1'b1;
      tick(half);
      o_scl <= 1'b1;
      tick(half);
      o_sda_oe_n <= 1'b0;
      tick(half);
      o_scl <= 1'b0;
   endtask

   task automatic stop();
      tick(2);
      o_sda_oe_n <= 1'b0;
      tick(half);
      o_scl <= 1'b1;
      tick(half);
      o_sda_oe_n <= 1'b1;
      tick(half);
   endtask

   // A one-cycle clock spike is shorter than the filter must swallow.
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      o_sda_oe_n <= b;
      tick(half);
      if (spike) begin
         o_scl <= 1'b1;
         tick(1);
         o_scl <= 1'b0;
         tick(half);
      end
      o_scl <= 1'b1;
      tick(half);
      r = i_sda;
      o_scl <= 1'b0;
   endtask

   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ack_in, ack_out);
   endtask
endmodule
`default_nettype wire

//--- testbench/iox_slave_front_tb.sv
// Testbench top for the serial slave front end.
`default_nettype none
module iox_slave_front_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                ce = 1'b1;
   logic                scl;
   logic                m_oe_n;
   logic                s_oe_n;
   logic [1:0]          p0 = 2'h0;
   logic [1:0]          p1 = 2'h0;
   logic [1:0]          p2 = 2'h0;
   logic [7:0]          pl = 8'h00;
   logic [7:0]          ph = 8'h00;
   logic [7:0]          lo;
   logic [7:0]          hi;
   logic [2:0]          rd_sel;
   iox_pkg::iox_wr_type wr;
   iox_pkg::iox_wr_type wq[$];
   int                  n_fail = 0;
   int                  n_tests = 0;
   wire logic           sda = m_oe_n & s_oe_n;
   wire logic           a0 = p0[1] ? (p0[0] ? sda : scl) : p0[0];
   wire logic           a1 = p1[1] ? (p1[0] ? sda : scl) : p1[0];
   wire logic           a2 = p2[1] ? (p2[0] ? sda : scl) : p2[0];
   wire logic [7:0]     rd_data = {5'h15, rd_sel};

   always #20 clk = ~clk;

   iox_slave_front #(.PORT_W(8)) iox_slave_front_i (
      .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_scl(scl), .i_sda(sda),
      .o_sda_oe_n(s_oe_n), .i_addr_select_pin_low(a0), .i_addr_select_pin_mid(a1),
      .i_addr_select_pin_high(a2), .i_port_low_pin_level_bits(pl),
      .i_port_high_pin_level_bits(ph), .o_pin_level_port_low(lo),
      .o_pin_level_port_high(hi), .o_rd_sel(rd_sel), .i_rd_data(rd_data), .o_wr(wr)
   );
   iox_master iox_master_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));

   always @(posedge clk)
      if (wr.valid === 1'b1)
         wq.push_back(wr);

   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   function automatic logic [6:0] dev_addr();
      logic [2:0] t;
      logic       a3;
      a3 = p0[1];
      case ({p2[1], p1[1]})
         2'b00: t = 3'h2;
         2'b01: t = 3'h1;
         2'b10: begin
            // Here the low pin's bus tie moves up one address bit.
            t  = {2'h3, p0[1]};
            a3 = 1'b0;
         end
         default: t = 3'h5;
      endcase
      return {t, a3, p2[0], p1[0], p0[0]};
   endfunction

   function automatic logic [7:0] exp_reg(input logic [2:0] r);
      return (r == 3'h0) ? pl : (r == 3'h1) ? ph : {5'h15, r};
   endfunction

   task automatic wb(input logic [7:0] d, input logic ea);
      logic [7:0] q;
      logic       a;
      iox_master_i.xfer(d, 1'b1, q, a);
      chk("ack", {11'h000, ea}, {11'h000, a});
   endtask

   task automatic t_pins();
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         pl <= 8'h1D ^ {8{k[0]}};
         ph <= 8'hB4 ^ {8{k[0]}};
         repeat (3) @(posedge clk);
         chk("pin low", {4'h0, 8'h1D ^ {8{k[0]}}}, {4'h0, lo});
         chk("pin high", {4'h0, 8'hB4 ^ {8{k[0]}}}, {4'h0, hi});
      end
      @(posedge clk);
      ce <= 1'b0;
      pl <= 8'h66;
      repeat (4) @(posedge clk);
      chk("frozen pin low", {4'h0, 8'hE2}, {4'h0, lo});
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk("thawed pin low", {4'h0, 8'h66}, {4'h0, lo});
   endtask

   // Every pin tie, each with its own address and with a neighbour's address.
   task automatic t_addr();
      for (int i = 0; i < 64; i++) begin
         {p2, p1, p0} <= i[5:0];
         repeat (2) @(posedge clk);
         for (int w = 0; w < 2; w++) begin
            iox_master_i.start();
            wb({dev_addr() ^ {6'h00, w[0]}, 1'b0}, w[0]);
            iox_master_i.stop();
         end
      end
   endtask

   task automatic t_cmds();
      iox_pkg::iox_wr_type e;
      for (int c = 0; c < 8; c++) begin
         wq.delete();
         iox_master_i.start();
         wb({dev_addr(), 1'b0}, 1'b0);
         wb({5'h15, c[2:0]}, 1'b0);
         iox_master_i.spike = (c == 4);
         wb(8'h5A ^ c[7:0], 1'b0);
         iox_master_i.spike = 1'b0;
         wb(8'hC3 ^ c[7:0], 1'b0);
         iox_master_i.stop();
         chk("write count", (c > 1) ? 12'h002 : 12'h000, 12'(wq.size()));
         for (int j = 0; j < wq.size() && j < 2; j++) begin
            e = wq[j];
            chk("write", {1'b0, c[2:0] ^ j[2:0], (j == 0) ? 8'h5A ^ c[7:0] : 8'hC3 ^ c[7:0]},
                {1'b0, e.sel, e.data});
         end
      end
   endtask

   // A slow master reads the pairs holding registers 1 and 5 three times each, ending on a refused byte.
   task automatic t_read();
      logic [7:0] q;
      logic       a;
      logic [2:0] r;
      wq.delete();
      iox_master_i.half = 40;
      for (int k = 0; k < 2; k++) begin
         r = k[0] ? 3'h5 : 3'h1;
         iox_master_i.start();
         wb({dev_addr(), 1'b0}, 1'b0);
         wb({5'h00, r}, 1'b0);
         iox_master_i.start();
         wb({dev_addr(), 1'b1}, 1'b0);
         for (int n = 0; n < 3; n++) begin
            iox_master_i.xfer(8'hFF, n == 2, q, a);
            chk("read", {4'h0, exp_reg(r ^ {2'h0, n[0]})}, {4'h0, q});
         end
         iox_master_i.stop();
      end
      chk("read writes", 12'h000, 12'(wq.size()));
   endtask

   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      t_pins();
      t_addr();
      t_cmds();
      t_read();
      final_report();
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      $display("unexpected run length expected %0d seen %0d", 100000, 100000);
      final_report();
   end
endmodule

bind iox_slave_front iox_props #(.PORT_W(PORT_W)) iox_props_i (.i_clk, .i_nrst, .i_ce,
   .i_scl, .o_sda_oe_n, .i_port_low_pin_level_bits, .i_port_high_pin_level_bits,
   .o_pin_level_port_low, .o_pin_level_port_high, .o_rd_sel, .o_wr);
`default_nettype wire
